// file: src/smcf_pkg.sv
package smcf_pkg;

   // ****************************************
   // sizes and pin order
   // ****************************************
   localparam int OPC_W      = 8;
   localparam int ADDR_BYTES = 3;
   localparam int ADDR_RX_W  = 24;
   localparam int ADDR_W     = 18;
   localparam int SYNC_W     = 4;
   localparam int PIN_CS     = 0;
   localparam int PIN_SCK    = 1;
   localparam int PIN_SI     = 2;
   localparam int PIN_HOLD   = 3;
   // deselected, clock low, not paused
   localparam logic [3:0] SYNC_RESET = 4'h9;

   // ****************************************
   // opcodes
   // ****************************************
   localparam logic [7:0] OPC_SET_LATCH    = 8'h06;
   localparam logic [7:0] OPC_CLEAR_LATCH  = 8'h04;
   localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
   localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OPC_MEM_READ     = 8'h03;
   localparam logic [7:0] OPC_FAST_READ    = 8'h0B;
   localparam logic [7:0] OPC_MEM_WRITE    = 8'h02;
   localparam logic [7:0] OPC_SLEEP        = 8'hB9;
   localparam logic [7:0] OPC_ID_READ      = 8'h9F;

   // ****************************************
   // status byte layout
   // ****************************************
   localparam int         STAT_WEL_POS    = 1;
   localparam logic [7:0] STAT_FIXED_ONES = 8'h40;
   localparam logic [7:0] STAT_CFG_MASK   = 8'h8C;
   localparam logic       WEL_RESET       = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_OPCODE = 3'h1,
      ST_ADDR   = 3'h3,
      ST_DATA   = 3'h2,
      ST_IGNORE = 3'h6
   } smcf_state_t;

   typedef enum logic [3:0] {
      CMD_NONE         = 4'h0,
      CMD_SET_LATCH    = 4'h1,
      CMD_CLEAR_LATCH  = 4'h2,
      CMD_STATUS_READ  = 4'h3,
      CMD_STATUS_WRITE = 4'h4,
      CMD_MEM_READ     = 4'h5,
      CMD_FAST_READ    = 4'h6,
      CMD_MEM_WRITE    = 4'h7,
      CMD_SLEEP        = 4'h8,
      CMD_ID_READ      = 4'h9,
      CMD_INVALID      = 4'hF
   } smcf_cmd_t;

endpackage

// file: src/smcf_sync.sv
`timescale 1ns/1ps

module smcf_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   // first stage feeds the second stage only
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end
      else
      begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;

endmodule

// file: src/smcf_shift_in.sv
`timescale 1ns/1ps

module smcf_shift_in #(
   parameter int WIDTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             clear,
   input  wire logic             shiftEn,
   input  wire logic             bitIn,
   output logic      [WIDTH-1:0] byteOut,
   output logic                  byteDone
);

   localparam int             CW   = $clog2(WIDTH);
   localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

   logic [WIDTH-1:0] shift_q;
   logic [CW-1:0]    count_q;
   logic             done_q;

   // msb arrives first, so older bits move up
   always_ff @(posedge ref_clk)
   begin
      if (srst || clear)
      begin
         shift_q <= '0;
         count_q <= '0;
         done_q  <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (shiftEn)
         begin
            shift_q <= {shift_q[WIDTH-2:0], bitIn};
            count_q <= count_q + 1'b1;
            done_q  <= (count_q == LAST);
         end
      end
   end

   assign byteOut  = shift_q;
   assign byteDone = done_q;

endmodule

// file: src/smcf_front_end.sv
`timescale 1ns/1ps

// Summary of operation
// - sample on rising, drive on falling
// - clock level at select picks mode
// - mode 3 skips edge before first toggle
// - first byte after select is opcode
// - one opcode per select interval
// - deselected: input ignored, output tristated
// - all bytes move msb first
// - three address bytes, low 18 used
// - bad opcode: ignore rest, tristate output
// - latch and status opcodes decoded
// - read, fast read, write opcodes decoded
// - nine opcodes, all others invalid
// - latch cleared after reset
// - set command sets latch; status shows it
// - deselect clears latch after write commands
// - eight bit status register
// - latch shown at status bit 1
// - status read repeats the status byte while clocked
// - pause: freeze, tristate output
module smcf_front_end (
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              csN,
   input  wire logic              sclk,
   input  wire logic              mosi,
   input  wire logic              holdN,
   input  wire logic [7:0]        statusCfg,
   output logic                   misoOut,
   output logic                   misoOe,
   output logic                   writeEnableFlag,
   output smcf_pkg::smcf_cmd_t    cmdKind,
   output logic                   cmdValid,
   output logic [smcf_pkg::ADDR_W-1:0] memAddr,
   output logic                   addrValid,
   output logic [7:0]             rxData,
   output logic                   rxValid,
   output logic                   frameEnd,
   output logic                   spiMode3
);
   import smcf_pkg::*;

   // ****************************************
   // pin synchronisers and edges
   // ****************************************
   logic [SYNC_W-1:0] pinsRaw;
   logic [SYNC_W-1:0] pinsSync;
   logic              csS;
   logic              sckS;
   logic              siS;
   logic              holdS;
   logic              csPrev_q;
   logic              sckPrev_q;

   assign pinsRaw[PIN_CS]   = csN;
   assign pinsRaw[PIN_SCK]  = sclk;
   assign pinsRaw[PIN_SI]   = mosi;
   assign pinsRaw[PIN_HOLD] = holdN;

   smcf_sync #(
      .WIDTH     (SYNC_W),
      .RESET_VAL (SYNC_RESET)
   ) uSync (
      .ref_clk (ref_clk),
      .srst    (srst),
      .asyncIn (pinsRaw),
      .syncOut (pinsSync)
   );

   assign csS   = pinsSync[PIN_CS];
   assign sckS  = pinsSync[PIN_SCK];
   assign siS   = pinsSync[PIN_SI];
   assign holdS = pinsSync[PIN_HOLD];

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         csPrev_q  <= 1'b1;
         sckPrev_q <= 1'b0;
      end
      else
      begin
         csPrev_q  <= csS;
         sckPrev_q <= sckS;
      end
   end

   // while paused every pin edge is dropped
   logic csFall;
   logic csRise;
   logic sckRise;
   logic sckFall;

   assign csFall  = holdS && csPrev_q && !csS;
   assign csRise  = holdS && !csPrev_q && csS;
   assign sckRise = holdS && !csS && !sckPrev_q && sckS;
   assign sckFall = holdS && !csS && sckPrev_q && !sckS;

   // ****************************************
   // frame state
   // ****************************************
   smcf_state_t state_q;
   smcf_cmd_t   cmd_q;
   logic        armed_q;
   logic        mode3_q;
   logic [1:0]  addrCnt_q;
   logic [ADDR_RX_W-1:0] addrShift_q;

   logic       rxShiftEn;
   logic [7:0] rxByte;
   logic       rxDone;
   logic       listening;

   // first rise counts only once the clock has been low
   assign listening = (state_q != ST_IDLE) && (state_q != ST_IGNORE);
   assign rxShiftEn = sckRise && armed_q && listening;

   smcf_shift_in #(
      .WIDTH (OPC_W)
   ) uShift (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clear    (csFall),
      .shiftEn  (rxShiftEn),
      .bitIn    (siS),
      .byteOut  (rxByte),
      .byteDone (rxDone)
   );

   // ****************************************
   // opcode decode
   // ****************************************
   smcf_cmd_t decodedCmd;
   logic      needsAddr;
   logic      clearsLatch;
   logic      opcodeDone;
   logic      addrDone;

   assign decodedCmd =
      (rxByte == OPC_SET_LATCH)    ? CMD_SET_LATCH    :
      (rxByte == OPC_CLEAR_LATCH)  ? CMD_CLEAR_LATCH  :
      (rxByte == OPC_STATUS_READ)  ? CMD_STATUS_READ  :
      (rxByte == OPC_STATUS_WRITE) ? CMD_STATUS_WRITE :
      (rxByte == OPC_MEM_READ)     ? CMD_MEM_READ     :
      (rxByte == OPC_FAST_READ)    ? CMD_FAST_READ    :
      (rxByte == OPC_MEM_WRITE)    ? CMD_MEM_WRITE    :
      (rxByte == OPC_SLEEP)        ? CMD_SLEEP        :
      (rxByte == OPC_ID_READ)      ? CMD_ID_READ      :
                                     CMD_INVALID;

   assign needsAddr = (decodedCmd == CMD_MEM_READ) ||
                      (decodedCmd == CMD_FAST_READ) ||
                      (decodedCmd == CMD_MEM_WRITE);
   assign clearsLatch = (cmd_q == CMD_CLEAR_LATCH) ||
                        (cmd_q == CMD_STATUS_WRITE) ||
                        (cmd_q == CMD_MEM_WRITE);
   assign opcodeDone = rxDone && (state_q == ST_OPCODE);
   assign addrDone   = rxDone && (state_q == ST_ADDR) &&
                       (addrCnt_q == 2'(ADDR_BYTES - 1));

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state_q     <= ST_IDLE;
         cmd_q       <= CMD_NONE;
         armed_q     <= 1'b0;
         mode3_q     <= 1'b0;
         addrCnt_q   <= 2'h0;
         addrShift_q <= '0;
      end
      else if (csFall)
      begin
         state_q   <= ST_OPCODE;
         cmd_q     <= CMD_NONE;
         mode3_q   <= sckS;
         armed_q   <= !sckS;
         addrCnt_q <= 2'h0;
      end
      else if (csRise || csS)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         if (sckFall)
            armed_q <= 1'b1;
         case (state_q)
            ST_OPCODE:
               if (opcodeDone)
               begin
                  cmd_q <= decodedCmd;
                  if (decodedCmd == CMD_INVALID)
                     state_q <= ST_IGNORE;
                  else if (needsAddr)
                     state_q <= ST_ADDR;
                  else
                     state_q <= ST_DATA;
               end
            ST_ADDR:
               if (rxDone)
               begin
                  addrShift_q <= {addrShift_q[ADDR_RX_W-9:0], rxByte};
                  addrCnt_q   <= addrCnt_q + 2'h1;
                  if (addrDone)
                     state_q <= ST_DATA;
               end
            ST_DATA:   state_q <= ST_DATA;
            ST_IGNORE: state_q <= ST_IGNORE;
            ST_IDLE:   state_q <= ST_IDLE;
            default:   state_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // write enable latch
   // ****************************************
   logic weFlag_q;

   // only the opcode and the deselect after it move the latch, never a status write byte
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         weFlag_q <= WEL_RESET;
      else if (opcodeDone && decodedCmd == CMD_SET_LATCH)
         weFlag_q <= 1'b1;
      else if (csRise && clearsLatch &&
               (state_q == ST_DATA || state_q == ST_ADDR))
         weFlag_q <= 1'b0;
   end

   // ****************************************
   // status byte and serial output
   // ****************************************
   logic [7:0] welBits;
   logic [7:0] statusByte;
   logic [7:0] txShift_q;
   logic       driving_q;
   logic       misoOut_q;
   logic       misoOe_q;
   logic       txLoad;

   assign welBits    = 8'(weFlag_q) << STAT_WEL_POS;
   assign statusByte = (statusCfg & STAT_CFG_MASK) | STAT_FIXED_ONES | welBits;
   assign txLoad     = opcodeDone && (decodedCmd == CMD_STATUS_READ);

   // the byte repeats for as long as the master clocks
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         txShift_q <= 8'h00;
         driving_q <= 1'b0;
         misoOut_q <= 1'b0;
      end
      else if (txLoad)
      begin
         txShift_q <= statusByte;
      end
      else if (csS || state_q != ST_DATA || cmd_q != CMD_STATUS_READ)
      begin
         driving_q <= 1'b0;
      end
      else if (sckFall)
      begin
         misoOut_q <= txShift_q[7];
         txShift_q <= {txShift_q[6:0], txShift_q[7]};
         driving_q <= 1'b1;
      end
   end

   // enable drops at once on deselect or pause
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         misoOe_q <= 1'b0;
      else
         misoOe_q <= driving_q && !csS && holdS &&
                     (state_q == ST_DATA);
   end

   // ****************************************
   // strobes toward the memory side
   // ****************************************
   smcf_cmd_t             cmdKind_q;
   logic                  cmdValid_q;
   logic [ADDR_W-1:0]     memAddr_q;
   logic                  addrValid_q;
   logic [7:0]            rxData_q;
   logic                  rxValid_q;
   logic                  frameEnd_q;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cmdKind_q   <= CMD_NONE;
         cmdValid_q  <= 1'b0;
         memAddr_q   <= '0;
         addrValid_q <= 1'b0;
         rxData_q    <= 8'h00;
         rxValid_q   <= 1'b0;
         frameEnd_q  <= 1'b0;
      end
      else
      begin
         cmdValid_q  <= opcodeDone;
         addrValid_q <= addrDone;
         rxValid_q   <= rxDone && (state_q == ST_DATA);
         frameEnd_q  <= csRise;
         if (opcodeDone)
            cmdKind_q <= decodedCmd;
         if (addrDone)
            memAddr_q <= {addrShift_q[ADDR_W-9:0], rxByte};
         if (rxDone)
            rxData_q <= rxByte;
      end
   end

   assign misoOut         = misoOut_q;
   assign misoOe          = misoOe_q;
   assign writeEnableFlag = weFlag_q;
   assign cmdKind         = cmdKind_q;
   assign cmdValid        = cmdValid_q;
   assign memAddr         = memAddr_q;
   assign addrValid       = addrValid_q;
   assign rxData          = rxData_q;
   assign rxValid         = rxValid_q;
   assign frameEnd        = frameEnd_q;
   assign spiMode3        = mode3_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking cbMain @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   logic [1:0] cmdsInFrame_q;

   always_ff @(posedge ref_clk)
   begin
      if (srst || csFall)
         cmdsInFrame_q <= 2'h0;
      else if (cmdValid_q && cmdsInFrame_q != 2'h3)
         cmdsInFrame_q <= cmdsInFrame_q + 2'h1;
   end

   sequence sqSelect;
      csFall;
   endsequence

   sequence sqSetLatch;
      opcodeDone && decodedCmd == CMD_SET_LATCH;
   endsequence

   sequence sqClearEnd;
      csRise && clearsLatch && state_q == ST_DATA;
   endsequence

   chk_out_on_fall: assert property (
      $changed(misoOut_q) |-> $past(sckFall))
      else $error("serial output changed without a falling clock");

   chk_mode_capture: assert property (
      sqSelect |=> mode3_q == $past(sckS))
      else $error("bus mode not taken from clock level");

   chk_mode3_skip: assert property (
      sqSelect ##0 sckS |=> !armed_q)
      else $error("mode 3 armed before the clock toggled");

   chk_opcode_first: assert property (
      sqSelect |=> state_q == ST_OPCODE && cmd_q == CMD_NONE)
      else $error("select did not start an opcode");

   chk_one_opcode: assert property (
      cmdValid_q |-> cmdsInFrame_q == 2'h0)
      else $error("second opcode in one select interval");

   chk_idle_quiet: assert property (
      csS [*2] |-> !misoOe_q && !rxValid_q)
      else $error("activity while deselected");

   chk_addr_width: assert property (
      addrValid_q |-> $past(state_q) == ST_ADDR && $past(addrCnt_q) == 2'h2)
      else $error("address taken before three bytes");

   chk_bad_opcode: assert property (
      state_q == ST_IGNORE |=> !misoOe_q && !addrValid_q && !rxValid_q)
      else $error("invalid opcode produced activity");

   chk_latch_reset: assert property (
      $fell(srst) |-> !weFlag_q)
      else $error("latch set after reset");

   chk_latch_set: assert property (
      sqSetLatch |=> weFlag_q ##1 cmdKind_q == CMD_SET_LATCH)
      else $error("set command did not set latch");

   chk_latch_clear: assert property (
      sqClearEnd |=> !weFlag_q)
      else $error("latch not cleared at end of write command");

   chk_status_wel: assert property (
      txLoad |=> txShift_q[STAT_WEL_POS] == weFlag_q && txShift_q[6])
      else $error("status byte does not show latch");

   chk_pause_quiet: assert property (
      !holdS |=> !misoOe_q)
      else $error("output driven during pause");

   chk_short_abort: assert property (
      csRise && state_q == ST_OPCODE |=> $stable(weFlag_q) && !cmdValid_q)
      else $error("partial opcode had an effect");

endmodule

// file: verification/smcf_master_model.sv
`timescale 1ns/1ps

// ****************************************
// serial bus master model
// ****************************************
module smcf_master_model #(
   parameter int HALF_NS = 24
) (
   input  wire logic ref_clk,
   input  wire logic misoWire,
   input  wire logic misoOe,
   output logic      csN,
   output logic      sclk,
   output logic      mosi,
   output logic      holdN
);
   logic [7:0] rxByte;
   logic       oeSeen;

   initial
   begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      holdN = 1'b1;
      rxByte = 8'h00;
      oeSeen = 1'b0;
   end

   always @(posedge ref_clk)
      if (misoOe === 1'b1)
         oeSeen <= 1'b1;

   // one select interval; outside it the clock only moves to its idle level
   task automatic frame(input logic mode3, input int nBits, input logic [39:0] tx, input int holdAt);
      int i;
      @(posedge ref_clk);
      #1;
      oeSeen = 1'b0;
      sclk = mode3;
      #(HALF_NS);
      csN = 1'b0;
      #(HALF_NS);
      for (i = 0; i < nBits; i++)
      begin
         sclk = 1'b0;
         mosi = tx[39-i];
         if (i == holdAt)
         begin
            holdN = 1'b0;
            repeat (3)
            begin
               #(HALF_NS);
               sclk = 1'b1;
               mosi = ~mosi;
               #(HALF_NS);
               sclk = 1'b0;
            end
            #(HALF_NS);
            holdN = 1'b1;
            mosi = tx[39-i];
         end
         #(HALF_NS);
         sclk = 1'b1;
         // late sample leaves room for the pin synchroniser delay
         #(HALF_NS-1);
         rxByte = {rxByte[6:0], misoWire};
         #1;
      end
      if (!mode3)
         sclk = 1'b0;
      #(HALF_NS);
      csN = 1'b1;
      mosi = ~mosi;
      #(4*HALF_NS);
   endtask
endmodule

// file: verification/smcf_front_end_tb.sv
`timescale 1ns/1ps

module smcf_front_end_tb;
   import smcf_pkg::*;

   localparam int LIMIT = 20000;

   logic                ref_clk;
   logic                srst;
   logic                csN;
   logic                sclk;
   logic                mosi;
   logic                holdN;
   logic [7:0]          statusCfg;
   logic                misoOut;
   logic                misoOe;
   logic                misoWire;
   logic                writeEnableFlag;
   smcf_cmd_t           cmdKind;
   logic                cmdValid;
   logic [ADDR_W-1:0]   memAddr;
   logic                addrValid;
   logic [7:0]          rxData;
   logic                rxValid;
   logic                frameEnd;
   logic                spiMode3;
   int                  failures;
   int                  checked;
   int                  cycles;
   int                  cmdCount;
   int                  endCount;
   int                  i;
   int                  n;
   smcf_cmd_t           cmdSeen;
   logic [ADDR_W-1:0]   addrSeen;
   logic [7:0]          rxSeen;
   logic [7:0]          op;
   logic [7:0]          cfg;
   logic [7:0]          data;
   logic [23:0]         addr;
   logic                write_enable_flag;
   logic [7:0]          ops [9] = '{OPC_SET_LATCH, OPC_CLEAR_LATCH, OPC_STATUS_READ, OPC_STATUS_WRITE,
                                    OPC_MEM_READ, OPC_FAST_READ, OPC_MEM_WRITE, OPC_SLEEP, OPC_ID_READ};

   assign misoWire = misoOe ? misoOut : 1'bz;

   smcf_front_end dut (
      .ref_clk         (ref_clk),
      .srst            (srst),
      .csN             (csN),
      .sclk            (sclk),
      .mosi            (mosi),
      .holdN           (holdN),
      .statusCfg       (statusCfg),
      .misoOut         (misoOut),
      .misoOe          (misoOe),
      .writeEnableFlag (writeEnableFlag),
      .cmdKind         (cmdKind),
      .cmdValid        (cmdValid),
      .memAddr         (memAddr),
      .addrValid       (addrValid),
      .rxData          (rxData),
      .rxValid         (rxValid),
      .frameEnd        (frameEnd),
      .spiMode3        (spiMode3)
   );

   smcf_master_model master (
      .ref_clk  (ref_clk),
      .misoWire (misoWire),
      .misoOe   (misoOe),
      .csN      (csN),
      .sclk     (sclk),
      .mosi     (mosi),
      .holdN    (holdN)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ****************************************
   // pulse capture and hang guard
   // ****************************************
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cmdValid === 1'b1)
      begin
         cmdSeen = cmdKind;
         cmdCount++;
      end
      if (addrValid === 1'b1)
         addrSeen = memAddr;
      if (rxValid === 1'b1)
         rxSeen = rxData;
      if (frameEnd === 1'b1)
         endCount++;
      if (cycles == LIMIT)
      begin
         failures++;
         print_verdict();
      end
   end

   // ****************************************
   // expectations
   // ****************************************
   function automatic smcf_cmd_t cmdOf(input logic [7:0] code);
      case (code)
         OPC_SET_LATCH:    return CMD_SET_LATCH;
         OPC_CLEAR_LATCH:  return CMD_CLEAR_LATCH;
         OPC_STATUS_READ:  return CMD_STATUS_READ;
         OPC_STATUS_WRITE: return CMD_STATUS_WRITE;
         OPC_MEM_READ:     return CMD_MEM_READ;
         OPC_FAST_READ:    return CMD_FAST_READ;
         OPC_MEM_WRITE:    return CMD_MEM_WRITE;
         OPC_SLEEP:        return CMD_SLEEP;
         OPC_ID_READ:      return CMD_ID_READ;
         default:          return CMD_INVALID;
      endcase
   endfunction

   function automatic logic welAfter(input logic w, input logic [7:0] code);
      if (code == OPC_SET_LATCH)
         return 1'b1;
      if (code == OPC_CLEAR_LATCH || code == OPC_STATUS_WRITE || code == OPC_MEM_WRITE)
         return 1'b0;
      return w;
   endfunction

   function automatic logic [7:0] statusOf(input logic [7:0] c, input logic w);
      return (c & 8'h8C) | 8'h40 | {6'h00, w, 1'b0};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic run(input logic m3, input int nBits, input logic [39:0] tx, input int holdAt = -1);
      int e;
      e = endCount;
      master.frame(m3, nBits, tx, holdAt);
      repeat (8) @(posedge ref_clk);
      #1;
      check(32'(misoOe), 32'h0);
      check(32'(endCount - e), 32'h1);
   endtask

   task automatic print_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      srst = 1'b1;
      statusCfg = 8'h00;
      failures = 0;
      checked = 0;
      cycles = 0;
      cmdCount = 0;
      endCount = 0;
      write_enable_flag = 1'b0;
      void'($urandom(32'h1dbb));
      repeat (5) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      check(32'(writeEnableFlag), 32'h0);
      check(32'(cmdKind), 32'(CMD_NONE));
      // every opcode, modes alternating, then random bytes
      for (i = 0; i < 14; i++)
      begin
         op = (i < 9) ? ops[i] : 8'($urandom);
         n = cmdCount;
         run(i[0], 8, {op, 32'h0});
         check(32'(cmdCount - n), 32'h1);
         check(32'(cmdSeen), 32'(cmdOf(op)));
         check(32'(spiMode3), 32'(i[0]));
         write_enable_flag = welAfter(write_enable_flag, op);
         check(32'(writeEnableFlag), 32'(write_enable_flag));
      end
      // status byte with random config, last one paused mid-opcode
      for (i = 0; i < 4; i++)
      begin
         cfg = 8'($urandom);
         statusCfg = cfg;
         if (i == 2)
         begin
            run(1'b0, 8, {OPC_SET_LATCH, 32'h0});
            write_enable_flag = 1'b1;
         end
         run(i[0], 16, {OPC_STATUS_READ, 32'h0}, (i == 3) ? 3 : -1);
         check(32'(master.rxByte), 32'(statusOf(cfg, write_enable_flag)));
      end
      addr = {6'h00, 18'($urandom)};
      data = 8'($urandom);
      run(1'b1, 8, {OPC_SET_LATCH, 32'h0});
      check(32'(writeEnableFlag), 32'h1);
      run(1'b1, 40, {OPC_MEM_WRITE, addr, data});
      check(32'(addrSeen), 32'(addr[17:0]));
      check(32'(rxSeen), 32'(data));
      check(32'(writeEnableFlag), 32'h0);
      // upper address bits must be dropped even when set
      addr = 24'($urandom) | 24'hFC0000;
      run(1'b0, 32, {OPC_FAST_READ, addr, 8'h00});
      check(32'(addrSeen), 32'(addr[17:0]));
      run(1'b0, 8, {OPC_SET_LATCH, 32'h0});
      run(1'b0, 16, {OPC_STATUS_WRITE, 8'h02, 24'h0});
      check(32'(writeEnableFlag), 32'h0);
      run(1'b0, 16, {OPC_STATUS_WRITE, 8'h02, 24'h0});
      check(32'(writeEnableFlag), 32'h0);
      // aborted opcode, second opcode in one frame, invalid opcode
      run(1'b0, 8, {OPC_SET_LATCH, 32'h0});
      n = cmdCount;
      run(1'b1, 5, {OPC_CLEAR_LATCH, 32'h0});
      check(32'(cmdCount - n), 32'h0);
      check(32'(writeEnableFlag), 32'h1);
      run(1'b0, 16, {OPC_SET_LATCH, OPC_CLEAR_LATCH, 24'h0});
      check(32'(cmdCount - n), 32'h1);
      check(32'(writeEnableFlag), 32'h1);
      check(32'(rxSeen), 32'(OPC_CLEAR_LATCH));
      run(1'b1, 16, {8'hFF, OPC_STATUS_READ, 24'h0});
      check(32'(cmdCount - n), 32'h2);
      check(32'(cmdSeen), 32'(CMD_INVALID));
      check(32'(master.oeSeen), 32'h0);
      check(32'(rxSeen), 32'(OPC_CLEAR_LATCH));
      check(32'(writeEnableFlag), 32'h1);
      print_verdict();
   end
endmodule
